// ==== sim/ncd_mem_model.sv ====
// Purpose: Program ROM and data RAM beside the nibble core
// Assumes: Both answer combinationally at the presented address
// Notes: ROM word is a fixed function of its address
`timescale 1ns/1ps
module ncd_mem_model (
  input wire logic clk_i, // System clock
  input wire logic [11:0] rom_addr_i, // Program address
  output logic [15:0] rom_data_o, // Program word
  input wire logic [9:0] ram_addr_i, // Data address
  input wire logic [3:0] ram_wdata_i, // Write nibble
  input wire logic ram_we_i, // Write strobe
  output logic [3:0] ram_rdata_o // Read nibble
);
  // ==========================================================
  // Storage
  logic [3:0] mem [0:1023];

  // Clear the RAM so reads of unused places are defined
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 4'h0;
    end
  end

  // ROM content, 4K words addressed by twelve bits
  assign rom_data_o = {4'h5, rom_addr_i ^ 12'h0A5};

  // RAM write on the strobe, combinational read
  always_ff @(posedge clk_i) begin
    if (ram_we_i) begin
      mem[ram_addr_i] <= ram_wdata_i;
    end
  end
  assign ram_rdata_o = mem[ram_addr_i];
endmodule : ncd_mem_model

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench of the nibble core datapath
// Assumes: Commands and registers reached over classic Wishbone
// Notes: Expected values worked out from operand values by hand
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  import ncd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, low_power = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_wdat = 32'h0, wb_rdat;
  logic wb_ack, ram_we, busy;
  logic [11:0] rom_addr;
  logic [15:0] rom_data;
  logic [9:0] ram_addr;
  logic [3:0] ram_wdata, ram_rdata;
  int errors = 0, n_compared = 0, cyc_cnt = 0;
  logic [31:0] rd;
  ncd_op_e logic_ops [3] = '{NCD_AND_OP, NCD_XOR_OP, NCD_OR_OP};
  logic [3:0] logic_exp [3] = '{4'hC, 4'h2, 4'hE};

  // ==========================================================
  // Clock, design and memories
  always #5 clk_i = ~clk_i;
  ncd_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .low_power_i(low_power), .rom_addr_o(rom_addr), .rom_data_i(rom_data), .ram_addr_o(ram_addr),
    .ram_wdata_o(ram_wdata), .ram_we_o(ram_we), .ram_rdata_i(ram_rdata), .busy_o(busy));
  ncd_mem_model mem_model (.clk_i(clk_i), .rom_addr_i(rom_addr), .rom_data_o(rom_data), .ram_addr_i(ram_addr),
    .ram_wdata_i(ram_wdata), .ram_we_i(ram_we), .ram_rdata_o(ram_rdata));

  // ==========================================================
  // Tasks
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w; wb_adr <= a; wb_wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("[ERR] %0t bus ack missing", $time);
    end
    q = wb_rdat;
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
  endtask : wb

  task automatic chkreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK(q & m, e)
  endtask : chkreg

  task automatic setnib(input logic [3:0] nb, input logic [3:0] tb, input logic cy);
    logic [31:0] q;
    wb(1'b1, NCD_REG_NIB, {23'h0, cy, tb, nb}, q);
  endtask : setnib

  // Issue one command and count its busy cycles
  task automatic run(input ncd_op_e op, input logic [2:0] s, input logic [3:0] im, input logic [11:0] a,
                     input bit acc = 1'b1);
    ncd_cmd_s c;
    logic [31:0] q;
    int n;
    c.op = op; c.sel = s; c.imm = im; c.addr = a;
    n = 0;
    wb(1'b1, NCD_REG_CMD, {8'h00, c}, q);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i);
      if (busy === 1'b1) n++;
      else if (n > 0) break;
    end
    repeat (2) @(posedge clk_i);
    `CHK(n, acc ? NCD_CYC_PER_INSN : 0)
  endtask : run

  task automatic pcis(input logic [11:0] e);
    chkreg(NCD_REG_PC, 32'hFFF, {20'h0, e});
  endtask : pcis

  function automatic logic cond(input logic [3:0] nb, input logic cy, input int s);
    if (s < 4) return nb[s];
    case (s)
      4: return nb == 4'h0;
      5: return nb != 4'h0;
      6: return cy;
      default: return !cy;
    endcase
  endfunction : cond

  // ==========================================================
  // Timeout
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    pcis(NCD_VEC_RESET);
    chkreg(NCD_REG_NIB, 32'h1FFF, 32'h0);
    chkreg(8'h10, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, NCD_REG_PC, 32'h555, rd);
    pcis(12'h000);
    // Arithmetic against RAM operand 9
    setnib(4'h9, 4'h0, 1'b0); run(NCD_STORE_OP, 3'h0, 4'h0, 12'h020);
    setnib(4'h8, 4'h0, 1'b0); run(NCD_ADD_OP, 3'h0, 4'h0, 12'h020);
    chkreg(NCD_REG_NIB, 32'h1FF, 32'h101);
    run(NCD_DECIMAL_ADJUST_ADD_OP, 3'h0, 4'h0, 12'h020);
    chkreg(NCD_REG_NIB, 32'h1FF, 32'h107);
    setnib(4'h3, 4'h0, 1'b0); run(NCD_SUB_OP, 3'h0, 4'h0, 12'h020);
    chkreg(NCD_REG_NIB, 32'h1FF, 32'h00A);
    run(NCD_DECIMAL_ADJUST_SUB_OP, 3'h0, 4'h0, 12'h020);
    chkreg(NCD_REG_NIB, 32'h1FF, 32'h004);
    setnib(4'h8, 4'h0, 1'b1); run(NCD_ADD_CARRY_OP, 3'h0, 4'h0, 12'h020);
    chkreg(NCD_REG_NIB, 32'h1FF, 32'h102);
    setnib(4'h3, 4'h0, 1'b0); run(NCD_SUB_CARRY_OP, 3'h0, 4'h0, 12'h020);
    chkreg(NCD_REG_NIB, 32'h1FF, 32'h009);
    run(NCD_ADD_OP, 3'h3, 4'h5, 12'h020); run(NCD_LOAD_OP, 3'h0, 4'h0, 12'h020);
    chkreg(NCD_REG_NIB, 32'hF, 32'hE);
    // Logic operations against RAM operand E
    for (int i = 0; i < 3; i++) begin
      setnib(4'hC, 4'h0, 1'b0); run(logic_ops[i], 3'h0, 4'h0, 12'h020);
      chkreg(NCD_REG_NIB, 32'hF, {28'h0, logic_exp[i]});
    end
    run(NCD_XOR_OP, 3'h3, 4'hF, 12'h020); run(NCD_LOAD_OP, 3'h0, 4'h0, 12'h020);
    chkreg(NCD_REG_NIB, 32'hF, 32'h1);
    setnib(4'hC, 4'h0, 1'b1); run(NCD_SHIFT_RIGHT_OP, 3'h0, 4'h0, 12'h000);
    chkreg(NCD_REG_NIB, 32'h1FF, 32'h106);
    // Page bit and ripple counter
    run(NCD_DIRECT_JUMP_OP, 3'h0, 4'h0, 12'h7FF); pcis(12'h7FF);
    run(NCD_NOP_OP, 3'h0, 4'h0, 12'h000); pcis(12'h000);
    run(NCD_DIRECT_JUMP_OP, 3'h0, 4'h0, 12'hFFF); pcis(12'hFFF);
    run(NCD_NOP_OP, 3'h0, 4'h0, 12'h000); pcis(12'h800);
    // Every branch condition; bit 1 and bit 3 tests are only seen not taken
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 8; s++) begin
        setnib(p ? 4'h0 : 4'h5, 4'h0, p == 0);
        run(NCD_DIRECT_JUMP_OP, 3'h0, 4'h0, 12'h800);
        run(NCD_COND_BRANCH_OP, 3'(s), 4'h0, 12'h123);
        pcis(cond(p ? 4'h0 : 4'h5, p == 0, s) ? 12'h923 : 12'h801);
      end
    end
    run(NCD_DIRECT_JUMP_OP, 3'h0, 4'h0, 12'hABC); setnib(4'h7, 4'h3, 1'b0);
    run(NCD_TABLE_JUMP_OP, 3'h0, 4'h0, 12'h000); pcis(12'hA37);
    // Carry saved by call, restored by interrupt return only
    setnib(4'h0, 4'h0, 1'b1); run(NCD_DIRECT_JUMP_OP, 3'h0, 4'h0, 12'h100);
    run(NCD_CALL_OP, 3'h0, 4'h0, 12'h200); pcis(12'h200);
    setnib(4'h0, 4'h0, 1'b0); run(NCD_RETURN_FROM_INTERRUPT_OP, 3'h0, 4'h0, 12'h000);
    pcis(12'h101); chkreg(NCD_REG_NIB, 32'h100, 32'h100);
    run(NCD_DIRECT_JUMP_OP, 3'h0, 4'h0, 12'h300); setnib(4'h0, 4'h0, 1'b1);
    run(NCD_CALL_OP, 3'h0, 4'h0, 12'h200); setnib(4'h0, 4'h0, 1'b0);
    run(NCD_RETURN_WITH_CONSTANT_OP, 3'h0, 4'h0, 12'h000); pcis(12'h301);
    chkreg(NCD_REG_NIB, 32'h1FF, 32'h0A5);
    // Five nested calls drop the oldest entry
    run(NCD_DIRECT_JUMP_OP, 3'h0, 4'h0, 12'h010);
    for (int i = 1; i <= 5; i++) run(NCD_CALL_OP, 3'h0, 4'h0, 12'(i << 8));
    chkreg(NCD_REG_NIB, 32'h1C00, {19'h0, NCD_DEPTH_MAX, 10'h0});
    for (int i = 4; i >= 1; i--) begin
      run(NCD_RETURN_FROM_INTERRUPT_OP, 3'h0, 4'h0, 12'h000); pcis(12'((i << 8) | 1));
    end
    chkreg(NCD_REG_NIB, 32'h1C00, 32'h0);
    // Interrupt vectors
    run(NCD_DIRECT_JUMP_OP, 3'h0, 4'h0, 12'h055);
    for (int v = 0; v <= 4; v++) begin
      run(NCD_INT_ENTRY_OP, 3'h0, 4'h0, 12'(v)); pcis(v == 0 ? NCD_VEC_FIRST : 12'(v));
      run(NCD_RETURN_FROM_INTERRUPT_OP, 3'h0, 4'h0, 12'h000); pcis(12'h055);
    end
    // Window through the pointer
    wb(1'b1, NCD_REG_PTR, 32'h35A, rd); chkreg(NCD_REG_PTR, 32'hFFFFFFFF, 32'h35A);
    setnib(4'h6, 4'h0, 1'b0); run(NCD_STORE_OP, 3'h0, 4'h0, 12'(NCD_WINDOW_ADDR));
    setnib(4'h0, 4'h0, 1'b0); run(NCD_LOAD_OP, 3'h0, 4'h0, 12'h1DA);
    chkreg(NCD_REG_NIB, 32'hF, 32'h6);
    // Low power refuses commands, memory kept
    @(posedge clk_i) low_power <= 1'b1;
    setnib(4'h9, 4'h0, 1'b0); run(NCD_STORE_OP, 3'h0, 4'h0, 12'h1DA, 1'b0);
    @(posedge clk_i) low_power <= 1'b0;
    run(NCD_LOAD_OP, 3'h0, 4'h0, 12'h1DA); chkreg(NCD_REG_NIB, 32'hF, 32'h6);
    end_of_test();
  end
endmodule : tb_top

// ==== verilog/ncd_core.sv ====
// Purpose: Datapath and program control of a 4-bit core, driven by commands
// Assumes: Program ROM and data RAM answer combinationally, held 4 cycles
// Notes: One command runs one instruction cycle of four clocks
//
// Functional notes
// - Twelve-bit counter: page bit plus eleven-bit counter
// - Direct jump also loads the page bit
// - Program address space is 4K words
// - Add and subtract with carry, three operand forms
// - Decimal adjust after addition and after subtraction
// - AND, XOR, OR with register, memory, immediate forms
// - Branch on nibble bits, zero, nonzero, carry states
// - Logical shift right of a nibble
// - Carry saved on call and interrupt, restored selectively
// - Four-bit work nibble carries all data moves
// - Table jump target is upper counter, table, nibble
// - Constant return loads table and work nibbles
// - Pointer parts 3, 3, 4 bits span 1K
// - Window accesses use the ten-bit pointer address
// - Four thirteen-bit entries hold carry plus counter
// - Stack is last-in first-out, restored on returns
// - Fifth nesting silently drops the oldest entry
// - Memory contents kept during low-power modes
// - Instruction cycle is four clock periods
// - Reset and interrupt vectors at fixed low addresses
`timescale 1ns/1ps
module ncd_core import ncd_pkg::*; (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Bus acknowledge
  input wire logic low_power_i, // Stop or halt mode
  output logic [11:0] rom_addr_o, // Program ROM address
  input wire logic [15:0] rom_data_i, // Program ROM word
  output logic [9:0] ram_addr_o, // Data RAM address
  output logic [3:0] ram_wdata_o, // Data RAM write nibble
  output logic ram_we_o, // Data RAM write strobe
  input wire logic [3:0] ram_rdata_i, // Data RAM read nibble
  output logic busy_o // Instruction in progress
);

  // ==========================================================
  // State
  typedef struct packed {
    logic page_select_bit;
    logic [10:0] ripple_count;
    logic [3:0] work_nibble_register;
    logic [3:0] table_branch_nibble;
    logic carry_flag;
    logic [2:0] pointer_high_part;
    logic [2:0] pointer_mid_part;
    logic [3:0] pointer_low_part;
    ncd_stk_entry_t [NCD_STK_DEPTH-1:0] stk;
    logic [2:0] depth;
    logic busy;
    logic [1:0] phase;
    ncd_cmd_s cmd;
    logic [11:0] rom_addr;
    logic [9:0] ram_addr;
    logic [3:0] ram_wdata;
    logic ram_we;
    logic ack;
    logic [31:0] dat;
  } ncd_state_s;

  ncd_state_s s_q;
  ncd_state_s s_d;

  logic [11:0] pc;
  logic commit;
  logic [9:0] ptr_addr;
  assign pc = {s_q.page_select_bit, s_q.ripple_count};
  assign commit = s_q.busy && (s_q.phase == NCD_LAST_PHASE);
  assign ptr_addr = {s_q.pointer_high_part, s_q.pointer_mid_part, s_q.pointer_low_part};

  // ==========================================================
  // Next state
  always_comb begin
    logic [3:0] x;
    logic [3:0] y;
    logic [4:0] sum;
    logic [3:0] res;
    logic take;
    logic push;
    logic pop;
    logic [NCD_STK_W-1:0] pushval;
    logic [9:0] a;
    logic wr;
    logic req;
    ncd_cmd_s nc;
    x = '0;
    y = '0;
    sum = '0;
    res = '0;
    take = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    pushval = '0;
    a = '0;
    nc = ncd_cmd_s'(wb_dat_i[$bits(ncd_cmd_s)-1:0]);
    req = wb_cyc_i && wb_stb_i;
    wr = req && wb_we_i && s_q.ack && wb_sel_i[0];
    s_d = s_q;
    s_d.ram_we = 1'b0;

    // Bus slave: ack one cycle after the request, dropped next cycle
    s_d.ack = req && !s_q.ack;
    if (req && !s_q.ack) begin
      unique case (wb_adr_i)
        NCD_REG_NIB: s_d.dat = {19'h00000, s_q.depth, s_q.busy, s_q.carry_flag,
                                s_q.table_branch_nibble, s_q.work_nibble_register};
        NCD_REG_PC: s_d.dat = {20'h00000, pc};
        NCD_REG_PTR: s_d.dat = {21'h000000, s_q.pointer_high_part, 1'b0,
                                s_q.pointer_mid_part, s_q.pointer_low_part};
        default: s_d.dat = 32'h00000000;
      endcase
    end

    // Register writes; all refused while an instruction runs
    if (wr && !s_q.busy) begin
      unique case (wb_adr_i)
        NCD_REG_CMD: begin
          if (!low_power_i) begin
            s_d.cmd = nc;
            s_d.busy = 1'b1;
            s_d.phase = '0;
            s_d.rom_addr = pc;
            a = nc.addr[NCD_RAM_AW-1:0];
            s_d.ram_addr = (a == NCD_WINDOW_ADDR) ? ptr_addr : a;
          end
        end
        NCD_REG_NIB: begin
          s_d.work_nibble_register = wb_dat_i[3:0];
          s_d.table_branch_nibble = wb_dat_i[7:4];
          s_d.carry_flag = wb_dat_i[8];
        end
        NCD_REG_PTR: begin
          s_d.pointer_low_part = wb_dat_i[3:0];
          s_d.pointer_mid_part = wb_dat_i[6:4];
          s_d.pointer_high_part = wb_dat_i[10:8];
        end
        default: ;
      endcase
    end

    // Four clocks per instruction, work done on the last
    if (s_q.busy && !commit) begin
      s_d.phase = s_q.phase + 2'h1;
    end
    if (commit) begin
      s_d.busy = 1'b0;
      s_d.ripple_count = s_q.ripple_count + NCD_SEQ_STEP;
      x = s_q.cmd.sel[1] ? ram_rdata_i : s_q.work_nibble_register;
      y = s_q.cmd.sel[1] ? s_q.cmd.imm : ram_rdata_i;
      unique case (s_q.cmd.op)
        NCD_ADD_OP, NCD_ADD_CARRY_OP, NCD_SUB_OP, NCD_SUB_CARRY_OP: begin
          if (s_q.cmd.op == NCD_SUB_OP || s_q.cmd.op == NCD_SUB_CARRY_OP) begin
            y = ~y;
          end
          sum = {1'b0, x} + {1'b0, y};
          if (s_q.cmd.op == NCD_SUB_OP) begin
            sum = sum + 5'h01;
          end else if (s_q.cmd.op != NCD_ADD_OP) begin
            sum = sum + {4'h0, s_q.carry_flag};
          end
          res = sum[3:0];
          s_d.carry_flag = sum[4];
        end
        NCD_DECIMAL_ADJUST_ADD_OP: begin
          res = s_q.work_nibble_register;
          if (s_q.work_nibble_register > NCD_BCD_MAX || s_q.carry_flag) begin
            sum = {1'b0, s_q.work_nibble_register} + NCD_BCD_FIX;
            res = sum[3:0];
            s_d.carry_flag = 1'b1;
          end
        end
        NCD_DECIMAL_ADJUST_SUB_OP: begin
          res = s_q.work_nibble_register;
          if (!s_q.carry_flag) begin
            res = s_q.work_nibble_register + NCD_BCD_SUBFIX;
          end
        end
        NCD_AND_OP: res = x & y;
        NCD_XOR_OP: res = x ^ y;
        NCD_OR_OP: res = x | y;
        NCD_SHIFT_RIGHT_OP: res = {1'b0, x[3:1]};
        NCD_LOAD_OP: res = ram_rdata_i;
        NCD_STORE_OP: res = s_q.work_nibble_register;
        default: res = s_q.work_nibble_register;
      endcase
      // Result goes to memory or to the work nibble
      unique case (s_q.cmd.op)
        NCD_ADD_OP, NCD_ADD_CARRY_OP, NCD_SUB_OP, NCD_SUB_CARRY_OP, NCD_AND_OP,
        NCD_XOR_OP, NCD_OR_OP, NCD_SHIFT_RIGHT_OP: begin
          if (s_q.cmd.sel[0]) begin
            s_d.ram_we = !low_power_i;
            s_d.ram_wdata = res;
          end else begin
            s_d.work_nibble_register = res;
          end
        end
        NCD_STORE_OP: begin
          s_d.ram_we = !low_power_i;
          s_d.ram_wdata = res;
        end
        NCD_DECIMAL_ADJUST_ADD_OP, NCD_DECIMAL_ADJUST_SUB_OP, NCD_LOAD_OP: s_d.work_nibble_register = res;
        default: ;
      endcase
      // Program flow
      unique case (s_q.cmd.op)
        NCD_COND_BRANCH_OP: begin
          unique case (s_q.cmd.sel)
            NCD_BRANCH_IF_ACC_ZERO: take = (s_q.work_nibble_register == NCD_ZERO_NIB);
            NCD_BRANCH_IF_ACC_NONZERO: take = (s_q.work_nibble_register != NCD_ZERO_NIB);
            NCD_BRANCH_IF_CARRY: take = s_q.carry_flag;
            NCD_BRANCH_IF_NO_CARRY: take = !s_q.carry_flag;
            default: take = s_q.work_nibble_register[s_q.cmd.sel[1:0]];
          endcase
          if (take) begin
            s_d.ripple_count = s_q.cmd.addr[10:0];
          end
        end
        NCD_DIRECT_JUMP_OP: {s_d.page_select_bit, s_d.ripple_count} = s_q.cmd.addr;
        NCD_TABLE_JUMP_OP: begin
          s_d.ripple_count = {pc[10:8], s_q.table_branch_nibble, s_q.work_nibble_register};
        end
        NCD_CALL_OP: begin
          push = 1'b1;
          pushval = {s_q.carry_flag, s_q.page_select_bit, s_q.ripple_count + NCD_SEQ_STEP};
          {s_d.page_select_bit, s_d.ripple_count} = s_q.cmd.addr;
        end
        NCD_INT_ENTRY_OP: begin
          push = 1'b1;
          pushval = {s_q.carry_flag, pc};
          {s_d.page_select_bit, s_d.ripple_count} = NCD_VEC_FIRST;
          if (s_q.cmd.addr >= NCD_VEC_FIRST && s_q.cmd.addr <= NCD_VEC_LAST) begin
            {s_d.page_select_bit, s_d.ripple_count} = s_q.cmd.addr;
          end
        end
        NCD_RETURN_WITH_CONSTANT_OP: begin
          pop = 1'b1;
          {s_d.page_select_bit, s_d.ripple_count} = s_q.stk[0][NCD_PC_W-1:0];
          s_d.table_branch_nibble = rom_data_i[7:4];
          s_d.work_nibble_register = rom_data_i[3:0];
        end
        NCD_RETURN_FROM_INTERRUPT_OP: begin
          pop = 1'b1;
          {s_d.carry_flag, s_d.page_select_bit, s_d.ripple_count} = s_q.stk[0];
        end
        default: ;
      endcase
    end

    // Stack shifts one place per push or pop
    if (push) begin
      for (int i = NCD_STK_DEPTH - 1; i > 0; i--) begin
        s_d.stk[i] = s_q.stk[i-1];
      end
      s_d.stk[0] = pushval;
      if (s_q.depth != NCD_DEPTH_MAX) begin
        s_d.depth = s_q.depth + 3'h1;
      end
    end else if (pop) begin
      for (int i = 0; i < NCD_STK_DEPTH - 1; i++) begin
        s_d.stk[i] = s_q.stk[i+1];
      end
      if (s_q.depth != 3'h0) begin
        s_d.depth = s_q.depth - 3'h1;
      end
    end
  end

  // Register the whole state; reset starts at the reset vector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      {s_q.page_select_bit, s_q.ripple_count} <= NCD_VEC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign rom_addr_o = s_q.rom_addr;
  assign ram_addr_o = s_q.ram_addr;
  assign ram_wdata_o = s_q.ram_wdata;
  assign ram_we_o = s_q.ram_we;
  assign busy_o = s_q.busy;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic start;
  // Phase is zero only in the first busy cycle, so no history is needed
  assign start = s_q.busy && (s_q.phase == 2'h0);

  a_insn_four_cycles: assert property (start |-> s_q.busy [*4] ##1 !s_q.busy)
    else $error("instruction length not four cycles");
  a_seq_no_page: assert property (commit && s_q.cmd.op inside {NCD_ADD_OP, NCD_AND_OP, NCD_NOP_OP}
    |=> s_q.ripple_count == $past(s_q.ripple_count) + NCD_SEQ_STEP
    && s_q.page_select_bit == $past(s_q.page_select_bit))
    else $error("sequential step wrong or page changed");
  a_jump_loads_page: assert property (commit && s_q.cmd.op == NCD_DIRECT_JUMP_OP
    |=> pc == $past(s_q.cmd.addr))
    else $error("direct jump target wrong");
  a_table_jump_addr: assert property (commit && s_q.cmd.op == NCD_TABLE_JUMP_OP
    |=> pc == {$past(pc[11:8]), $past(s_q.table_branch_nibble), $past(s_q.work_nibble_register)})
    else $error("table jump target wrong");
  a_call_push_carry: assert property (commit && s_q.cmd.op == NCD_CALL_OP
    |=> s_q.stk[0] == {$past(s_q.carry_flag), $past(pc[11]), $past(pc[10:0]) + NCD_SEQ_STEP}
    && s_q.stk[1] == $past(s_q.stk[0]))
    else $error("call did not push carry and return address");
  a_rti_restores: assert property (commit && s_q.cmd.op == NCD_RETURN_FROM_INTERRUPT_OP
    |=> {s_q.carry_flag, pc} == $past(s_q.stk[0]))
    else $error("interrupt return did not restore");
  a_rtw_keeps_carry: assert property (commit && s_q.cmd.op == NCD_RETURN_WITH_CONSTANT_OP
    |=> s_q.carry_flag == $past(s_q.carry_flag)
    && {s_q.table_branch_nibble, s_q.work_nibble_register} == $past(rom_data_i[7:0]))
    else $error("constant return wrong");
  a_window_addr: assert property (start && s_q.cmd.addr[9:0] == NCD_WINDOW_ADDR |-> ram_addr_o == ptr_addr)
    else $error("window address not from pointer");
  a_low_power_hold: assert property (ram_we_o |-> !$past(low_power_i))
    else $error("memory written in low-power mode");
  a_reset_vector: assert property ($past(rst_i) |-> pc == NCD_VEC_RESET)
    else $error("counter not at reset vector");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  c_stack_overflow: cover property (commit && s_q.cmd.op == NCD_CALL_OP && s_q.depth == NCD_DEPTH_MAX);
  c_table_jump: cover property (commit && s_q.cmd.op == NCD_TABLE_JUMP_OP);
  c_int_return: cover property (commit && s_q.cmd.op == NCD_RETURN_FROM_INTERRUPT_OP);
endmodule : ncd_core

// ==== verilog/ncd_pkg.sv ====
// Purpose: Shared constants and types of the nibble core datapath
// Assumes: 100 MHz clock, classic Wishbone register access
// Notes: Command word layout is ncd_cmd_s, op field on top
package ncd_pkg;
  // ==========================================================
  // Widths and sizes
  localparam int NCD_PC_W = 12;
  localparam int NCD_RAM_AW = 10;
  localparam int NCD_STK_DEPTH = 4;
  localparam int NCD_STK_W = 13;
  localparam int NCD_CYC_PER_INSN = 4;
  localparam logic [1:0] NCD_LAST_PHASE = 2'(NCD_CYC_PER_INSN - 1);
  localparam logic [2:0] NCD_DEPTH_MAX = 3'(NCD_STK_DEPTH);

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] NCD_REG_CMD = 8'h00;
  localparam logic [7:0] NCD_REG_NIB = 8'h04;
  localparam logic [7:0] NCD_REG_PC = 8'h08;
  localparam logic [7:0] NCD_REG_PTR = 8'h0C;

  // ==========================================================
  // Fixed addresses and ALU constants
  localparam logic [11:0] NCD_VEC_RESET = 12'h000;
  localparam logic [11:0] NCD_VEC_FIRST = 12'h001;
  localparam logic [11:0] NCD_VEC_LAST = 12'h004;
  localparam logic [9:0] NCD_WINDOW_ADDR = 10'h00F;
  localparam logic [3:0] NCD_BCD_MAX = 4'h9;
  localparam logic [4:0] NCD_BCD_FIX = 5'h06;
  localparam logic [3:0] NCD_BCD_SUBFIX = 4'hA;
  localparam logic [3:0] NCD_ZERO_NIB = 4'h0;
  localparam logic [10:0] NCD_SEQ_STEP = 11'h001;

  // ==========================================================
  // Operations
  typedef enum logic [4:0] {
    NCD_NOP_OP, NCD_ADD_OP, NCD_ADD_CARRY_OP, NCD_SUB_OP, NCD_SUB_CARRY_OP,
    NCD_DECIMAL_ADJUST_ADD_OP, NCD_DECIMAL_ADJUST_SUB_OP,
    NCD_AND_OP, NCD_XOR_OP, NCD_OR_OP, NCD_SHIFT_RIGHT_OP,
    NCD_COND_BRANCH_OP, NCD_DIRECT_JUMP_OP, NCD_TABLE_JUMP_OP, NCD_CALL_OP,
    NCD_INT_ENTRY_OP, NCD_RETURN_WITH_CONSTANT_OP, NCD_RETURN_FROM_INTERRUPT_OP,
    NCD_LOAD_OP, NCD_STORE_OP
  } ncd_op_e;

  // Branch condition selectors, 0 to 3 test a work nibble bit
  localparam logic [2:0] NCD_BRANCH_IF_ACC_ZERO = 3'h4;
  localparam logic [2:0] NCD_BRANCH_IF_ACC_NONZERO = 3'h5;
  localparam logic [2:0] NCD_BRANCH_IF_CARRY = 3'h6;
  localparam logic [2:0] NCD_BRANCH_IF_NO_CARRY = 3'h7;

  // Command word: sel[0] memory destination, sel[1] immediate operand
  typedef struct packed {
    ncd_op_e op;
    logic [2:0] sel;
    logic [3:0] imm;
    logic [11:0] addr;
  } ncd_cmd_s;

  typedef logic [NCD_STK_W-1:0] ncd_stk_entry_t;
endpackage : ncd_pkg
